// ---- csit_defines.vh ----
// Constants for the clock select and interval timer block
`ifndef CSIT_DEFINES_VH
`define CSIT_DEFINES_VH

// Register indices; byte address is four times the index
`define CSIT_IDX_CPU_CLK_CFG   10'h030
`define CSIT_IDX_TMR_CLK_CFG   10'h031
`define CSIT_IDX_FAST_TRIM     10'h034
`define CSIT_IDX_SLOW_TRIM     10'h036
`define CSIT_IDX_RELOAD_LO     10'h038
`define CSIT_IDX_RELOAD_HI     10'h039
`define CSIT_IDX_COUNT_LO      10'h03a
`define CSIT_IDX_COUNT_HI      10'h03b
`define CSIT_IDX_SYS_CTRL      10'h0ff
`define CSIT_IDX_OSC_CTRL0     10'h1e0

// Reset values
`define CSIT_RST_CPU_CLK_CFG   8'h00
`define CSIT_RST_TMR_CLK_CFG   8'h8f
`define CSIT_RST_OSC_CTRL0     8'h00

// Field positions
`define CSIT_OSC_SPEED_LSB     0
`define CSIT_OSC_SLEEPT_LSB    3
`define CSIT_OSC_NOBUZZ_BIT    5
`define CSIT_TMR_ISEL_LSB      0
`define CSIT_TMR_IDIV_LSB      2
`define CSIT_TMR_CSEL_LSB      4
`define CSIT_TMR_CDIV_LSB      6
`define CSIT_SYS_SLEEP_BIT     3

// Source codes of the clock muxes
`define CSIT_SRC_FAST          2'b00
`define CSIT_SRC_EXT           2'b01
`define CSIT_SRC_SLOW          2'b10
`define CSIT_SRC_CAP           2'b11

// Timing counts
`define CSIT_WAKE_SLOW_CYCLES  2'd3
`define CSIT_MS_TICK_DIV       12'hfff

`endif

// ---- csit_clock_timer.v ----
// Clock selection, division, sleep control and 12-bit interval timer
`timescale 1ns/1ps
`default_nettype none
`include "csit_defines.vh"

// Glitch-free source mux plus divider; sources arrive as one-cycle ticks
module csit_clk_sel_div (
    input  wire       pclk,
    input  wire       presetn,
    input  wire [3:0] src_ticks,
    input  wire [1:0] req_sel,
    input  wire [7:0] divisor,
    output reg  [1:0] act_sel_q,
    output reg        tick_q
);
    reg  [7:0] cnt_q;
    reg        seen_old_q;
    reg        seen_new_q;
    wire       old_tick;
    wire       new_tick;

    assign old_tick = src_ticks[act_sel_q];
    assign new_tick = src_ticks[req_sel];

    // Switch only once both clocks have ticked, so a dead source blocks the change
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_sel_q  <= 2'b00;
            seen_old_q <= 1'b0;
            seen_new_q <= 1'b0;
        end else if (req_sel == act_sel_q) begin
            seen_old_q <= 1'b0;
            seen_new_q <= 1'b0;
        end else if ((seen_old_q | old_tick) & (seen_new_q | new_tick)) begin
            act_sel_q  <= req_sel;
            seen_old_q <= 1'b0;
            seen_new_q <= 1'b0;
        end else begin
            seen_old_q <= seen_old_q | old_tick;
            seen_new_q <= seen_new_q | new_tick;
        end
    end

    // Divider restarts on a switch; ticks are always a full pclk wide
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else if ((req_sel != act_sel_q) & (seen_old_q | old_tick) & (seen_new_q | new_tick)) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else if (old_tick) begin
            if (cnt_q >= divisor - 8'h01) begin
                cnt_q  <= 8'h00;
                tick_q <= 1'b1;
            end else begin
                cnt_q  <= cnt_q + 8'h01;
                tick_q <= 1'b0;
            end
        end else begin
            tick_q <= 1'b0;
        end
    end
endmodule

module csit_clock_timer #(
    parameter [7:0] FAST_TRIM_3V3 = 8'h10,
    parameter [7:0] SLOW_TRIM_3V3 = 8'h28
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_q,
    output reg         pready_q,
    output reg         pslverr_q,
    input  wire        fast_osc_tick,
    input  wire        slow_osc_tick,
    input  wire        xtal_osc_tick,
    input  wire        xtal_osc_enable,
    input  wire        ext_clock_input,
    input  wire        sleep_duty_window,
    input  wire        wake_request,
    output reg         core_clock_q,
    output reg         capture_timer_clock_q,
    output reg         interval_timer_clock_q,
    output reg         ms_tick_q,
    output reg         sleep_timer_tick_q,
    output reg         detector_enable_q,
    output reg         interval_irq_q,
    output reg         sleeping_q,
    output reg  [7:0]  fast_osc_trim_q,
    output reg  [7:0]  slow_osc_trim_q
);
    reg  [7:0]  cpu_clock_config_q;
    reg  [7:0]  timer_clock_config_q;
    reg  [7:0]  osc_control_zero_q;
    reg  [11:0] interval_reload_value_q;
    reg  [11:0] interval_count_q;
    reg         reload_pending_q;
    reg         ext_in_q;
    reg  [1:0]  wake_cnt_q;
    reg         waking_q;
    reg  [14:0] sleep_div_q;
    reg  [11:0] ms_div_q;
    reg  [31:0] rdata_d;
    reg         map_hit_d;

    wire [9:0]  reg_idx;
    wire        wr_en;
    wire        ext_tick;
    wire        core_tick;
    wire        cap_tick;
    wire        itmr_tick;
    wire [1:0]  core_act;
    wire [1:0]  cap_act;
    wire [1:0]  itmr_act;
    wire [1:0]  core_req;
    wire [1:0]  cap_req;
    wire        sleep_tick_d;
    wire        acc_phase;
    wire        cap_live;
    wire [2:0]  cpu_speed;
    wire [1:0]  sleep_sel;
    wire        no_buzz;
    wire [1:0]  cap_sel;
    wire [1:0]  cap_div;
    wire [1:0]  itmr_sel;
    wire [1:0]  itmr_div;

    // CPU speed code to divide ratio, same ratios for both sources
    function [7:0] speed_div;
        input [2:0] code;
        begin
            case (code)
                3'b000:  speed_div = 8'd8;
                3'b001:  speed_div = 8'd4;
                3'b010:  speed_div = 8'd2;
                3'b100:  speed_div = 8'd16;
                3'b101:  speed_div = 8'd32;
                3'b110:  speed_div = 8'd128;
                default: speed_div = 8'd8;   // Reserved codes behave as default
            endcase
        end
    endfunction

    // Sleep timer tick from the slow oscillator prescaler
    function sleep_tap;
        input [1:0]  code;
        input [14:0] cnt;
        begin
            case (code)
                2'b00:   sleep_tap = &cnt[5:0];
                2'b01:   sleep_tap = &cnt[8:0];
                2'b10:   sleep_tap = &cnt[11:0];
                default: sleep_tap = &cnt[14:0];
            endcase
        end
    endfunction

    // Access phase of a transfer; writes land at its ready edge and only on a mapped, aligned word
    assign reg_idx   = paddr[11:2];
    assign acc_phase = psel & penable & pready_q;
    assign wr_en     = acc_phase & pwrite & map_hit_d;

    // Configuration fields as the clock trees and sleep logic use them
    assign cpu_speed = osc_control_zero_q[`CSIT_OSC_SPEED_LSB +: 3];
    assign sleep_sel = osc_control_zero_q[`CSIT_OSC_SLEEPT_LSB +: 2];
    assign no_buzz   = osc_control_zero_q[`CSIT_OSC_NOBUZZ_BIT];
    assign cap_sel   = timer_clock_config_q[`CSIT_TMR_CSEL_LSB +: 2];
    assign cap_div   = timer_clock_config_q[`CSIT_TMR_CDIV_LSB +: 2];
    assign itmr_sel  = timer_clock_config_q[`CSIT_TMR_ISEL_LSB +: 2];
    assign itmr_div  = timer_clock_config_q[`CSIT_TMR_IDIV_LSB +: 2];

    // External oscillator comes from the crystal when enabled, else the pin
    assign ext_tick = xtal_osc_enable ? xtal_osc_tick : (ext_clock_input & ~ext_in_q);

    // Sleep forces the core source back to the internal oscillator
    assign core_req = (sleeping_q | waking_q) ? `CSIT_SRC_FAST :
                      (cpu_clock_config_q[0] ? `CSIT_SRC_EXT : `CSIT_SRC_FAST);

    // Reserved capture code maps to the stopped input
    assign cap_req = (cap_sel == 2'b01) ? `CSIT_SRC_CAP : cap_sel;

    // Stop input reads live until the stop takes hold, then dead: stopping needs no second clock,
    // yet leaving the stopped state waits for a tick that never comes
    assign cap_live = (cap_act != `CSIT_SRC_CAP);

    csit_clk_sel_div u_core (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_ticks ({1'b0, slow_osc_tick, ext_tick, fast_osc_tick}),
        .req_sel   (core_req),
        .divisor   (speed_div(cpu_speed)),
        .act_sel_q (core_act),
        .tick_q    (core_tick)
    );

    // Capture clock: code 11 stops it once the running source has ticked
    csit_clk_sel_div u_cap (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_ticks ({cap_live, slow_osc_tick, 1'b0, fast_osc_tick}),
        .req_sel   (cap_req),
        .divisor   ({5'd0, cap_div, 1'b0} + 8'd2),
        .act_sel_q (cap_act),
        .tick_q    (cap_tick)
    );

    // Interval clock: reserved 01 selects a dead input and is refused
    csit_clk_sel_div u_itmr (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_ticks ({cap_tick, slow_osc_tick, 1'b0, fast_osc_tick}),
        .req_sel   (itmr_sel),
        .divisor   ({6'd0, itmr_div} + 8'd1),
        .act_sel_q (itmr_act),
        .tick_q    (itmr_tick)
    );

    // Registered clock pulses; core clock is held off in sleep and recovery
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_in_q               <= 1'b0;
            core_clock_q           <= 1'b0;
            capture_timer_clock_q  <= 1'b0;
            interval_timer_clock_q <= 1'b0;
        end else begin
            ext_in_q               <= ext_clock_input;
            core_clock_q           <= core_tick & ~sleeping_q & ~waking_q;
            capture_timer_clock_q  <= cap_tick;
            interval_timer_clock_q <= itmr_tick;
        end
    end

    // 1024 us tick: 4096 capture clocks, so it scales with that clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_div_q  <= 12'h000;
            ms_tick_q <= 1'b0;
        end else begin
            ms_tick_q <= cap_tick & (ms_div_q == `CSIT_MS_TICK_DIV);
            if (cap_tick)
                ms_div_q <= ms_div_q + 12'h001;
        end
    end

    // Sleep timer prescaler runs on the slow oscillator
    assign sleep_tick_d = slow_osc_tick & sleep_tap(sleep_sel, sleep_div_q);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_div_q        <= 15'h0000;
            sleep_timer_tick_q <= 1'b0;
        end else begin
            sleep_timer_tick_q <= sleep_tick_d;
            if (slow_osc_tick)
                sleep_div_q <= sleep_div_q + 15'h0001;
        end
    end

    // Sleep entry by software, wake by request, then three slow cycles of recovery
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleeping_q <= 1'b0;
            waking_q   <= 1'b0;
            wake_cnt_q <= 2'd0;
        end else if (sleeping_q) begin
            if (wake_request) begin
                sleeping_q <= 1'b0;
                waking_q   <= 1'b1;
                wake_cnt_q <= 2'd0;
            end
        end else if (waking_q) begin
            if (slow_osc_tick) begin
                if (wake_cnt_q == `CSIT_WAKE_SLOW_CYCLES - 2'd1)
                    waking_q <= 1'b0;
                wake_cnt_q <= wake_cnt_q + 2'd1;
            end
        end else if (wr_en & (reg_idx == `CSIT_IDX_SYS_CTRL) & pwdata[`CSIT_SYS_SLEEP_BIT]) begin
            sleeping_q <= 1'b1;
        end
    end

    // Detector runs always when awake; in sleep, duty window unless no-buzz set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            detector_enable_q <= 1'b1;
        else
            detector_enable_q <= ~sleeping_q | no_buzz | sleep_duty_window;
    end

    // Interval counter: zero costs one clock to reload and raises a request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_count_q <= 12'h000;
            interval_irq_q   <= 1'b0;
        end else if (itmr_tick) begin
            if (interval_count_q == 12'h000) begin
                interval_count_q <= interval_reload_value_q;
                interval_irq_q   <= 1'b1;
            end else begin
                interval_count_q <= interval_count_q - 12'h001;
                interval_irq_q   <= 1'b0;
            end
        end else begin
            interval_irq_q <= 1'b0;
        end
    end

    // Register writes; halves of the reload land separately, software keeps them paired
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clock_config_q      <= `CSIT_RST_CPU_CLK_CFG;
            timer_clock_config_q    <= `CSIT_RST_TMR_CLK_CFG;
            osc_control_zero_q      <= `CSIT_RST_OSC_CTRL0;
            fast_osc_trim_q         <= FAST_TRIM_3V3;
            slow_osc_trim_q         <= SLOW_TRIM_3V3;
            interval_reload_value_q <= 12'h000;
        end else if (wr_en) begin
            case (reg_idx)
                `CSIT_IDX_CPU_CLK_CFG: cpu_clock_config_q      <= {7'd0, pwdata[0]};
                `CSIT_IDX_TMR_CLK_CFG: timer_clock_config_q    <= pwdata[7:0];
                `CSIT_IDX_OSC_CTRL0:   osc_control_zero_q      <= {2'b00, pwdata[5:0]};
                `CSIT_IDX_FAST_TRIM:   fast_osc_trim_q         <= pwdata[7:0];
                `CSIT_IDX_SLOW_TRIM:   slow_osc_trim_q         <= {pwdata[7], 1'b0, pwdata[5:0]};
                `CSIT_IDX_RELOAD_LO:   interval_reload_value_q <= {interval_reload_value_q[11:8], pwdata[7:0]};
                `CSIT_IDX_RELOAD_HI:   interval_reload_value_q <= {pwdata[3:0], interval_reload_value_q[7:0]};
                default: ;
            endcase
        end
    end

    // Read mux; counter is sampled raw, software double-reads on slow clock
    always @* begin
        rdata_d   = 32'h0000_0000;
        map_hit_d = 1'b1;
        case (reg_idx)
            `CSIT_IDX_CPU_CLK_CFG: rdata_d[7:0] = cpu_clock_config_q;
            `CSIT_IDX_TMR_CLK_CFG: rdata_d[7:0] = timer_clock_config_q;
            `CSIT_IDX_OSC_CTRL0:   rdata_d[7:0] = osc_control_zero_q;
            `CSIT_IDX_FAST_TRIM:   rdata_d[7:0] = fast_osc_trim_q;
            `CSIT_IDX_SLOW_TRIM:   rdata_d[7:0] = slow_osc_trim_q;
            `CSIT_IDX_RELOAD_LO:   rdata_d[7:0] = interval_reload_value_q[7:0];
            `CSIT_IDX_RELOAD_HI:   rdata_d[3:0] = interval_reload_value_q[11:8];
            `CSIT_IDX_COUNT_LO:    rdata_d[7:0] = interval_count_q[7:0];
            `CSIT_IDX_COUNT_HI:    rdata_d[3:0] = interval_count_q[11:8];
            `CSIT_IDX_SYS_CTRL:    rdata_d[3]   = sleeping_q;
            default:               map_hit_d    = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00 || paddr[31:12] != 20'h00000)
            map_hit_d = 1'b0;
    end

    // APB: one wait-free access phase, data and error captured in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel & ~penable) begin
            pready_q  <= 1'b1;
            prdata_q  <= pwrite ? 32'h0000_0000 : (map_hit_d ? rdata_d : 32'h0000_0000);
            pslverr_q <= ~map_hit_d;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- csit_clock_timer_chk.sv ----
// Port checker for the clock select and interval timer block
`timescale 1ns/1ps
`default_nettype none
module csit_chk #(
    parameter [7:0] FAST_TRIM_3V3 = 8'h10,
    parameter [7:0] SLOW_TRIM_3V3 = 8'h28
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready_q,
    input wire logic        pslverr_q,
    input wire logic        sleep_duty_window,
    input wire logic        core_clock_q,
    input wire logic        capture_timer_clock_q,
    input wire logic        interval_timer_clock_q,
    input wire logic        ms_tick_q,
    input wire logic        detector_enable_q,
    input wire logic        interval_irq_q,
    input wire logic        sleeping_q,
    input wire logic [7:0]  fast_osc_trim_q,
    input wire logic [7:0]  slow_osc_trim_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answers with one wait-free access; error only beside ready
    a_apb_ready_next: assert property (psel && !penable |=> pready_q) else $error("ready late");
    a_ready_one_cycle: assert property (pready_q |=> !pready_q) else $error("ready held");
    a_err_needs_ready: assert property (pslverr_q |-> pready_q) else $error("error without ready");
    // Trims come up at the 3.30V set
    a_trim_reset_set: assert property ($rose(presetn) |-> fast_osc_trim_q == FAST_TRIM_3V3
        && slow_osc_trim_q == SLOW_TRIM_3V3) else $error("trim reset wrong");
    // Sleep write takes hold within one or two cycles, and the core clock stays gated once sleep has held four cycles
    a_sleep_entry: assert property (psel && penable && pready_q && pwrite && paddr == 32'h3fc && pwdata[3]
        |-> ##[1:2] sleeping_q) else $error("sleep not entered");
    a_core_gated: assert property (sleeping_q [*4] |-> !core_clock_q) else $error("core clock asleep");
    // Smallest divisor is two, so a pulse right after a pulse is a runt
    a_core_no_runt: assert property (core_clock_q |=> !core_clock_q) else $error("core runt");
    a_cap_no_runt: assert property (capture_timer_clock_q |=> !capture_timer_clock_q) else $error("cap runt");
    // Reload request only next to an interval clock pulse
    a_irq_on_tick: assert property (interval_irq_q |-> interval_timer_clock_q
        || $past(interval_timer_clock_q) || $past(interval_timer_clock_q, 2)) else $error("irq without tick");
    // An open duty window keeps the detector on in sleep
    a_detect_window: assert property (sleeping_q && $past(sleeping_q) && sleep_duty_window
        && $past(sleep_duty_window) |-> detector_enable_q) else $error("detector off in window");
    cover property (pslverr_q);
    cover property (interval_irq_q);
    cover property (sleeping_q && !detector_enable_q);
    cover property ($fell(sleeping_q));
    cover property (ms_tick_q);
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the clock select and interval timer block
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic        pclk, presetn, psel, penable, pwrite, fast_osc_tick, slow_osc_tick, xtal_osc_tick;
    logic        xtal_osc_enable, ext_clock_input, sleep_duty_window, wake_request, er;
    logic [31:0] paddr, pwdata, rd, r;
    logic [3:0]  ph;
    wire  [31:0] prdata_q;
    wire         pready_q, pslverr_q, core_clock_q, capture_timer_clock_q, interval_timer_clock_q, ms_tick_q;
    wire         sleep_timer_tick_q, detector_enable_q, interval_irq_q, sleeping_q;
    wire  [7:0]  fast_osc_trim_q, slow_osc_trim_q;
    wire  [5:0]  mon = {interval_irq_q, sleep_timer_tick_q, ms_tick_q, interval_timer_clock_q,
                        capture_timer_clock_q, core_clock_q};
    integer      n_mismatch = 0, check_count = 0, seed = 5183, cyc = 0, p, i;
    logic [7:0]  mdl [int];
    logic [31:0] wa [6] = '{32'h0c0, 32'h780, 32'h0d0, 32'h0d8, 32'h0e0, 32'h0e4};
    logic [7:0]  wm [6] = '{8'h01, 8'h3f, 8'hff, 8'hbf, 8'hff, 8'h0f};
    logic [31:0] ra [5] = '{32'h0c0, 32'h0c4, 32'h780, 32'h0d0, 32'h0d8};
    logic [7:0]  rv [5] = '{8'h00, 8'h8f, 8'h00, 8'h10, 8'h28};
    integer      dv [8] = '{8, 4, 2, 8, 16, 32, 128, 8};

    csit_clock_timer #(.FAST_TRIM_3V3(8'h10), .SLOW_TRIM_3V3(8'h28)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .fast_osc_tick, .slow_osc_tick, .xtal_osc_tick,
        .xtal_osc_enable, .ext_clock_input, .sleep_duty_window, .wake_request, .core_clock_q, .capture_timer_clock_q,
        .interval_timer_clock_q, .ms_tick_q, .sleep_timer_tick_q, .detector_enable_q, .interval_irq_q, .sleeping_q,
        .fast_osc_trim_q, .slow_osc_trim_q);

    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end

    // Oscillators: fast every 2 cycles, crystal every 4, slow every 8, pin period 16
    always @(posedge pclk) begin
        ph <= ph + 4'h1;
        cyc <= cyc + 1;
        fast_osc_tick <= ph[0];
        xtal_osc_tick <= ph[1:0] == 2'h0;
        slow_osc_tick <= ph[2:0] == 3'h0;
        ext_clock_input <= ph[3];
    end

    // One bus transfer; the request stands until ready is sampled high
    task apb(input [31:0] a, input w, input [31:0] d);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            k = 0;
            do begin @(posedge pclk); k++; end while (pready_q !== 1'b1 && k < 20);
            `chk("pready", 1'b1, pready_q)
            rd = prdata_q;
            er = pslverr_q;
            psel <= 0;
            penable <= 0;
        end
    endtask

    // Waits for a monitored pulse; a stuck clock ends the wait via the bound
    task pulse(input integer s);
        integer k;
        begin
            k = 0;
            do begin @(posedge pclk); k++; end while (mon[s] !== 1'b1 && k < 40000);
        end
    endtask

    // Period after two settling pulses, since dividers restart on a change
    task per(input integer s, output integer q);
        begin
            pulse(s); pulse(s); q = cyc; pulse(s); q = cyc - q;
        end
    endtask

    task stop_test;
        begin
            if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask

    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        stop_test;
    end

    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0; ph = 0; fast_osc_tick = 0;
        slow_osc_tick = 0; xtal_osc_tick = 0; ext_clock_input = 0; xtal_osc_enable = 1;
        sleep_duty_window = 0; wake_request = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 5; i++) begin apb(ra[i], 0, 0); `chk("reset value", rv[i], rd[7:0]) end
        per(2, p); `chk("default interval clock", 48, p)
        // Random writes against the register model, then unmapped and misaligned places
        for (i = 0; i < 6; i++) begin r = $random(seed); apb(wa[i], 1, r); mdl[wa[i]] = r[7:0] & wm[i]; end
        for (i = 0; i < 6; i++) begin apb(wa[i], 0, 0); `chk("readback", mdl[wa[i]], rd[7:0]) end
        apb(32'h100, 1, 32'h5); `chk("unmapped error", 1'b1, er)
        apb(32'h0c1, 0, 0); `chk("misaligned error", 1'b1, er)
        `chk("error data", 32'h0, rd)
        apb(32'h0c5, 1, 32'hff); apb(32'h0c4, 0, 0); `chk("misaligned write ignored", 8'h8f, rd[7:0])
        // Core clock over every speed code, then crystal and pin
        apb(32'h0c0, 1, 0);
        for (i = 0; i < 8; i++) begin apb(32'h780, 1, i); per(0, p); `chk("core period", 2 * dv[i], p) end
        apb(32'h780, 1, 2); apb(32'h0c0, 1, 1);
        per(0, p); `chk("crystal core period", 8, p)
        xtal_osc_enable <= 0;
        per(0, p); `chk("pin core period", 32, p)
        xtal_osc_enable <= 1;
        apb(32'h0c0, 1, 0);
        // Capture and interval dividers on the fast source, then slow and capture sources
        for (i = 0; i < 4; i++) begin
            apb(32'h0c4, 1, (i << 6) | (i << 2));
            per(1, p); `chk("capture period", 4 * (i + 1), p)
            per(2, p); `chk("interval clock period", 2 * (i + 1), p)
            if (i == 0) begin pulse(3); p = cyc; pulse(3); `chk("ms tick period", 4 * 4096, cyc - p) end
        end
        apb(32'h0c4, 1, 32'h22); per(1, p); `chk("slow capture period", 16, p)
        per(2, p); `chk("slow interval period", 8, p)
        apb(32'h0c4, 1, 32'h23); per(2, p); `chk("capture-fed interval", 16, p)
        // Interval timer with random reloads written low then high
        apb(32'h0c4, 1, 0);
        for (i = 0; i < 2; i++) begin
            r = $random(seed) & 32'h3ff;
            apb(32'h0e0, 1, r[7:0]); apb(32'h0e4, 1, r[11:8]);
            per(5, p); `chk("reload irq period", 2 * (r + 1), p)
        end
        // Slow interval clock: a count is taken once two reads in a row agree
        apb(32'h0e4, 1, 0); apb(32'h0e0, 1, 32'h3c); pulse(5); pulse(5); apb(32'h0c4, 1, 32'h02);
        apb(32'h0e8, 0, 0);
        i = 0;
        do begin r = rd; apb(32'h0e8, 0, 0); i++; end while (rd !== r && i < 6);
        `chk("count double-read", r, rd)
        `chk("count in range", 1'b1, rd <= 32'h3c)
        apb(32'h0ec, 0, 0); `chk("count high", 32'h0, rd)
        // Sleep with detector forced, then duty window, then wake
        apb(32'h780, 1, 32'h21); apb(32'h3fc, 1, 32'h8);
        repeat (3) @(posedge pclk);
        `chk("sleeping", 1'b1, sleeping_q)
        `chk("detector forced", 1'b1, detector_enable_q)
        per(4, p); `chk("sleep period 0", 512, p)
        apb(32'h780, 1, 32'h09); per(4, p); `chk("sleep period 1", 4096, p)
        `chk("detector duty off", 1'b0, detector_enable_q)
        sleep_duty_window <= 1;
        repeat (3) @(posedge pclk);
        `chk("detector duty on", 1'b1, detector_enable_q)
        sleep_duty_window <= 0;
        apb(32'h3fc, 0, 0); `chk("sleep readback", 1'b1, rd[3])
        wake_request <= 1;
        p = cyc;
        @(posedge pclk);
        wake_request <= 0;
        pulse(0); p = cyc - p;
        `chk("wake after three slow ticks", 1'b1, p > 16 && p < 50)
        `chk("awake", 1'b0, sleeping_q)
        // Stopped capture clock cannot be switched away from; reset recovers
        apb(32'h0c4, 1, 32'h30);
        repeat (20) @(posedge pclk);
        apb(32'h0c4, 1, 32'h00);
        p = 0;
        repeat (200) begin @(posedge pclk); p += mon[1]; end
        `chk("capture stays stopped", 0, p)
        presetn <= 0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        per(1, p); `chk("capture after reset", 12, p)
        stop_test;
    end
endmodule

bind csit_clock_timer csit_chk #(.FAST_TRIM_3V3(FAST_TRIM_3V3), .SLOW_TRIM_3V3(SLOW_TRIM_3V3)) chk_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready_q, .pslverr_q, .sleep_duty_window, .core_clock_q,
    .capture_timer_clock_q, .interval_timer_clock_q, .ms_tick_q, .detector_enable_q, .interval_irq_q, .sleeping_q,
    .fast_osc_trim_q, .slow_osc_trim_q);
`default_nettype wire
